// File: verilog/audio_out_pkg.sv
// Shared constants and types for the rate converter output port and its host
package audio_out_pkg;

    // Master clock and reset stretch
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned RESET_HOLD_MS = 350;
    localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / MS_PER_S);

    // Sampling domain: input word clock is the master clock over this divider
    localparam int unsigned IN_RATE_DIV = 128;
    localparam int unsigned DIV_W = $clog2(IN_RATE_DIV);

    // Output word clock limits, in master clocks per output sample
    localparam int unsigned OUT_MIN_RATIO = 130;
    localparam int unsigned MAX_RATIO = 3750;
    localparam int unsigned PER_W = $clog2(MAX_RATIO + 1);
    localparam int unsigned RATE_TOL = 2;
    localparam int unsigned LOCK_SETTLE_PERIODS = 4200;

    // Converter data path
    localparam int unsigned ADC_LATENCY = 5;
    localparam int unsigned ADC_BITS = 24;
    localparam int unsigned CHANNELS = 4;
    localparam int unsigned SLOT_BITS = 32;
    localparam int unsigned SLOT_IDX_W = $clog2(SLOT_BITS);
    localparam int unsigned I2S_DELAY = 1;
    localparam logic [SLOT_BITS-1:0] POS_FULL_SCALE = 32'h7fffffff;
    localparam logic [SLOT_BITS-1:0] DITHER_TAPS = 32'h80200003;

    // Serial frame lengths in bit clocks
    localparam int unsigned LJ_BCLK_PER_FRAME = 64;
    localparam int unsigned TDM_BCLK_PER_FRAME = 128;
    localparam int unsigned IDX_W = $clog2(TDM_BCLK_PER_FRAME);
    localparam int unsigned MIN_BCLK_HALF = 2;

    // Output format strap layout
    localparam int unsigned STRAP_W = 4;
    localparam int unsigned STRAP_WLEN_LSB = 0;
    localparam int unsigned STRAP_FMT_LSB = 2;

    typedef enum logic [1:0] {FMT_LJ, FMT_I2S, FMT_RJ, FMT_TDM} framing_t;
    typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} word_len_t;

    localparam logic [5:0] WL16_BITS = 6'h10;
    localparam logic [5:0] WL20_BITS = 6'h14;
    localparam logic [5:0] WL24_BITS = 6'h18;
    localparam logic [5:0] WL32_BITS = 6'h20;

    function automatic logic [5:0] len_bits(word_len_t w);
        unique case (w)
            WL_16: return WL16_BITS;
            WL_20: return WL20_BITS;
            WL_24: return WL24_BITS;
            WL_32: return WL32_BITS;
        endcase
    endfunction

endpackage

// File: verilog/audio_link_if.sv
// Serial audio link between the converter output port and the host receiver
`timescale 1ns/1ps
`default_nettype none

interface audio_link_if;
    logic output_word_clock;
    logic serial_bit_clock;
    logic serial_out_line_a;
    logic serial_out_line_b;

    modport device (
        input output_word_clock,
        input serial_bit_clock,
        output serial_out_line_a,
        output serial_out_line_b
    );

    modport host (
        output output_word_clock,
        output serial_bit_clock,
        input serial_out_line_a,
        input serial_out_line_b
    );
endinterface

`default_nettype wire

// File: verilog/dither_lfsr.sv
// Free-running noise source for output dither
`timescale 1ns/1ps
`default_nettype none

module dither_lfsr #(
    parameter logic [audio_out_pkg::SLOT_BITS-1:0] SEED = 32'h0000_0001
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Noise word, new value every clock
    output logic [audio_out_pkg::SLOT_BITS-1:0] noise
);
    import audio_out_pkg::*;

    typedef struct packed {
        logic [SLOT_BITS-1:0] lfsr;
    } lfsr_state_t;

    lfsr_state_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Galois step; a zero seed would lock up, so reset loads a nonzero constant
        st_nxt.lfsr = {1'b0, st_r.lfsr[SLOT_BITS-1:1]} ^ (st_r.lfsr[0] ? DITHER_TAPS : '0);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r.lfsr <= SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign noise = st_r.lfsr;
endmodule // dither_lfsr

`default_nettype wire

// File: verilog/src_audio_out.sv
// Rate converter output end: slave serial port, dither, lock tracking, status
`timescale 1ns/1ps
`default_nettype none

module src_audio_out #(
    parameter int unsigned HOLD_CYCLES = audio_out_pkg::RESET_HOLD_CYCLES,
    parameter int unsigned LOCK_PERIODS = audio_out_pkg::LOCK_SETTLE_PERIODS
) (
    // Clock and power-up reset
    input wire logic clock,
    input wire logic rst_n,
    // Reset sources and straps
    input wire logic button_rst_n,
    input wire logic ext_rst_n,
    input wire logic format_jumper,
    input wire logic [audio_out_pkg::STRAP_W-1:0] output_format_strap,
    // Sampling domain
    output logic input_word_clock,
    input wire logic [audio_out_pkg::CHANNELS-1:0][audio_out_pkg::ADC_BITS-1:0] sample_in,
    input wire logic [1:0] overflow_in,
    // Status
    output logic [1:0] overflow_out,
    output logic [1:0] rate_converter_unlock_flag,
    // Serial link
    audio_link_if.device link
);
    import audio_out_pkg::*;

    localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam int unsigned STABLE_W = $clog2(LOCK_PERIODS + 1);

    typedef logic [CHANNELS-1:0][ADC_BITS-1:0] sample_set_t;

    typedef struct packed {
        logic [HOLD_W-1:0] hold;
        framing_t fmt;
        word_len_t wlen;
        logic [DIV_W-1:0] div;
        sample_set_t [ADC_LATENCY-1:0] delay;
        logic [1:0] ovf;
        logic wprev;
        logic [PER_W-1:0] per_cnt;
        logic [PER_W-1:0] per_last;
        logic [STABLE_W-1:0] stable;
        logic unlock;
        logic bclk_q;
        logic wclk_q;
        logic [IDX_W-1:0] bit_idx;
        logic [CHANNELS-1:0][SLOT_BITS-1:0] frame;
        logic line_a;
        logic line_b;
    } dev_state_t;

    dev_state_t st_r, st_nxt;
    logic [SLOT_BITS-1:0] noise_l, noise_r;
    logic [CHANNELS-1:0][SLOT_BITS-1:0] fresh;
    logic in_reset, rise, fall, wclk, new_slot, is_left;
    logic [IDX_W-SLOT_IDX_W-1:0] ch;

    function automatic logic [SLOT_BITS-1:0] rot_half(logic [SLOT_BITS-1:0] x);
        return {x[SLOT_BITS/2-1:0], x[SLOT_BITS-1:SLOT_BITS/2]};
    endfunction

    // Rectangular dither below the kept LSB, then truncate; saturates at full scale
    function automatic logic [SLOT_BITS-1:0] dither_word(logic [ADC_BITS-1:0] s,
            logic [SLOT_BITS-1:0] n, word_len_t w);
        logic [SLOT_BITS-1:0] ext;
        logic [SLOT_BITS-1:0] mask;
        logic [SLOT_BITS:0] sum;
        logic [5:0] drop;
        drop = 6'(SLOT_BITS) - len_bits(w);
        ext = {s, {(SLOT_BITS - ADC_BITS){1'b0}}};
        mask = (32'h1 << drop) - 32'h1;
        sum = {1'b0, ext} + {1'b0, n & mask};
        if (!ext[SLOT_BITS-1] && sum[SLOT_BITS-1]) begin
            return POS_FULL_SCALE & ~mask;
        end
        return sum[SLOT_BITS-1:0] & ~mask;
    endfunction

    // Bit of a slot at a given position for the selected framing
    function automatic logic slot_bit(logic [SLOT_BITS-1:0] w, logic [SLOT_IDX_W-1:0] i,
            framing_t f, word_len_t l);
        int off;
        int p;
        off = (f == FMT_I2S) ? int'(I2S_DELAY) :
              (f == FMT_RJ) ? int'(SLOT_BITS) - int'(len_bits(l)) : 0;
        p = int'(i) - off;
        if (p < 0 || p >= int'(len_bits(l))) begin
            return 1'b0;
        end
        return w[SLOT_IDX_W'(int'(SLOT_BITS) - 1 - p)];
    endfunction

    function automatic logic period_bad(logic [PER_W-1:0] p, logic [PER_W-1:0] last);
        logic [PER_W-1:0] diff;
        diff = (p > last) ? p - last : last - p;
        return (p < PER_W'(OUT_MIN_RATIO)) || (p >= PER_W'(MAX_RATIO))
            || (diff > PER_W'(RATE_TOL));
    endfunction

    // Separate noise sources keep left and right dither uncorrelated
    dither_lfsr #(.SEED(32'h1234_5679)) u_noise_l (
        .clock(clock),
        .rst_n(rst_n),
        .noise(noise_l)
    );
    dither_lfsr #(.SEED(32'h9e37_79b9)) u_noise_r (
        .clock(clock),
        .rst_n(rst_n),
        .noise(noise_r)
    );

    // Oldest delay stage feeds the output, giving the ADC latency
    assign fresh[0] = dither_word(st_r.delay[ADC_LATENCY-1][0], noise_l, st_r.wlen);
    assign fresh[1] = dither_word(st_r.delay[ADC_LATENCY-1][1], noise_r, st_r.wlen);
    assign fresh[2] = dither_word(st_r.delay[ADC_LATENCY-1][2], rot_half(noise_l), st_r.wlen);
    assign fresh[3] = dither_word(st_r.delay[ADC_LATENCY-1][3], rot_half(noise_r), st_r.wlen);

    always_comb begin
        st_nxt = st_r;
        in_reset = (st_r.hold != '0) || !ext_rst_n;
        wclk = link.output_word_clock;
        new_slot = 1'b0;
        is_left = 1'b0;
        ch = '0;

        // Reset stretch: button reloads, power-up loads it under rst_n
        if (!button_rst_n) begin
            st_nxt.hold = HOLD_W'(HOLD_CYCLES);
        end else if (st_r.hold != '0) begin
            st_nxt.hold = st_r.hold - 1'b1;
        end

        // Sampling domain runs off the master clock alone
        st_nxt.div = st_r.div + 1'b1;
        if (st_r.div == DIV_W'(IN_RATE_DIV - 1)) begin
            st_nxt.delay = {st_r.delay[ADC_LATENCY-2:0], sample_in};
        end
        st_nxt.ovf = overflow_in;

        // Output rate tracking on the host's word clock
        st_nxt.wprev = wclk;
        rise = wclk && !st_r.wprev;
        if (rise) begin
            st_nxt.per_cnt = PER_W'(1);
            st_nxt.per_last = st_r.per_cnt;
            if (period_bad(st_r.per_cnt, st_r.per_last)) begin
                st_nxt.unlock = 1'b1;
                st_nxt.stable = '0;
            end else begin
                if (st_r.stable != STABLE_W'(LOCK_PERIODS)) begin
                    st_nxt.stable = st_r.stable + 1'b1;
                end
                if (st_nxt.stable == STABLE_W'(LOCK_PERIODS)) begin
                    st_nxt.unlock = 1'b0;
                end
            end
        end else if (st_r.per_cnt == PER_W'(MAX_RATIO)) begin
            // Word clock stopped or far too slow
            st_nxt.unlock = 1'b1;
            st_nxt.stable = '0;
        end else begin
            st_nxt.per_cnt = st_r.per_cnt + 1'b1;
        end

        // Serializer: data changes on the falling bit clock, host samples on rising
        st_nxt.bclk_q = link.serial_bit_clock;
        fall = st_r.bclk_q && !link.serial_bit_clock;
        if (fall) begin
            st_nxt.wclk_q = wclk;
            new_slot = (st_r.fmt == FMT_TDM) ? (wclk && !st_r.wclk_q) : (wclk != st_r.wclk_q);
            st_nxt.bit_idx = new_slot ? '0 : st_r.bit_idx + 1'b1;
            is_left = (st_r.fmt == FMT_TDM) || (wclk == (st_r.fmt != FMT_I2S));
            // One latch for all channels keeps every output phase aligned
            if (new_slot && is_left) begin
                st_nxt.frame = st_r.unlock ? '0 : fresh;
            end
            if (st_r.fmt == FMT_TDM) begin
                ch = st_nxt.bit_idx[IDX_W-1:SLOT_IDX_W];
                st_nxt.line_a = 1'b0;
                st_nxt.line_b = slot_bit(st_nxt.frame[ch], st_nxt.bit_idx[SLOT_IDX_W-1:0],
                                         st_r.fmt, st_r.wlen);
            end else begin
                ch = is_left ? '0 : 2'h1;
                st_nxt.line_a = slot_bit(st_nxt.frame[ch], st_nxt.bit_idx[SLOT_IDX_W-1:0],
                                         st_r.fmt, st_r.wlen);
                st_nxt.line_b = slot_bit(st_nxt.frame[ch + 2'h2],
                                         st_nxt.bit_idx[SLOT_IDX_W-1:0], st_r.fmt, st_r.wlen);
            end
        end

        if (in_reset) begin
            // Straps are captured while reset is held and frozen at release
            st_nxt.fmt = format_jumper ? FMT_TDM :
                framing_t'(output_format_strap[STRAP_FMT_LSB +: $bits(framing_t)]);
            st_nxt.wlen = word_len_t'(output_format_strap[STRAP_WLEN_LSB +: $bits(word_len_t)]);
            st_nxt.unlock = 1'b1;
            st_nxt.stable = '0;
            st_nxt.per_cnt = '0;
            st_nxt.frame = '0;
            st_nxt.bit_idx = '0;
            st_nxt.wclk_q = 1'b0;
            st_nxt.line_a = 1'b0;
            st_nxt.line_b = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.hold <= HOLD_W'(HOLD_CYCLES);
            st_r.wlen <= WL_24;
            st_r.unlock <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Both pairs share the same clocks, so their lock state is identical
    assign rate_converter_unlock_flag = {2{st_r.unlock}};
    assign overflow_out = st_r.ovf;
    assign input_word_clock = st_r.div[DIV_W-1];
    assign link.serial_out_line_a = st_r.line_a;
    assign link.serial_out_line_b = st_r.line_b;
endmodule // src_audio_out

`default_nettype wire

// File: verilog/audio_host_rx.sv
// Host receiver end: makes word and bit clocks, deserializes the data lines
`timescale 1ns/1ps
`default_nettype none

module audio_host_rx #(
    parameter int unsigned BCLK_HALF = audio_out_pkg::MIN_BCLK_HALF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Mode: high selects four-channel TDM, low dual left-justified
    input wire logic tdm_mode,
    // Received words
    output logic [audio_out_pkg::SLOT_BITS-1:0] rx_word_a,
    output logic [audio_out_pkg::SLOT_BITS-1:0] rx_word_b,
    output logic [1:0] rx_slot,
    output logic rx_valid,
    // Serial link
    audio_link_if.host link
);
    import audio_out_pkg::*;

    // No faster than the minimum keeps the frame period above the converter's limit
    localparam int unsigned HALF_EFF = (BCLK_HALF > MIN_BCLK_HALF) ? BCLK_HALF : MIN_BCLK_HALF;
    localparam int unsigned HALF_W = $clog2(HALF_EFF + 1);

    typedef struct packed {
        logic [HALF_W-1:0] half;
        logic bclk;
        logic wclk;
        logic [IDX_W-1:0] idx;
        logic [SLOT_BITS-1:0] sh_a;
        logic [SLOT_BITS-1:0] sh_b;
        logic [SLOT_BITS-1:0] word_a;
        logic [SLOT_BITS-1:0] word_b;
        logic [1:0] slot;
        logic valid;
    } host_state_t;

    host_state_t st_r, st_nxt;
    logic [IDX_W-1:0] last_idx;

    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        last_idx = tdm_mode ? IDX_W'(TDM_BCLK_PER_FRAME - 1) : IDX_W'(LJ_BCLK_PER_FRAME - 1);
        if (st_r.half == HALF_W'(HALF_EFF - 1)) begin
            st_nxt.half = '0;
            st_nxt.bclk = !st_r.bclk;
            if (st_r.bclk) begin
                st_nxt.idx = (st_r.idx == last_idx) ? '0 : st_r.idx + 1'b1;
                st_nxt.wclk = tdm_mode ? (st_nxt.idx == '0) : (st_nxt.idx < IDX_W'(SLOT_BITS));
            end else begin
                st_nxt.sh_a = {st_r.sh_a[SLOT_BITS-2:0], link.serial_out_line_a};
                st_nxt.sh_b = {st_r.sh_b[SLOT_BITS-2:0], link.serial_out_line_b};
                if (st_r.idx[SLOT_IDX_W-1:0] == '1) begin
                    st_nxt.word_a = st_nxt.sh_a;
                    st_nxt.word_b = st_nxt.sh_b;
                    st_nxt.slot = st_r.idx[IDX_W-1:SLOT_IDX_W];
                    st_nxt.valid = 1'b1;
                end
            end
        end else begin
            st_nxt.half = st_r.half + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.bclk <= 1'b1;
            st_r.idx <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.output_word_clock = st_r.wclk;
    assign link.serial_bit_clock = st_r.bclk;
    assign rx_word_a = st_r.word_a;
    assign rx_word_b = st_r.word_b;
    assign rx_slot = st_r.slot;
    assign rx_valid = st_r.valid;
endmodule // audio_host_rx

`default_nettype wire

// File: dv/src_serial_audio_output_port_chk.sv
// Concurrent checks on the serial audio link and the lock status
`timescale 1ns/1ps
`default_nettype none

module src_serial_audio_output_port_chk #(
    parameter int unsigned LOCK_PERIODS = 4
) (
    // Clock, reset and mode
    input wire logic clock,
    input wire logic rst_n,
    input wire logic format_jumper,
    // Converter status
    input wire logic input_word_clock,
    input wire logic [1:0] rate_converter_unlock_flag,
    // Link signals
    input wire logic output_word_clock,
    input wire logic serial_bit_clock,
    input wire logic serial_out_line_a,
    input wire logic serial_out_line_b
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic wclk_r;
    logic bclk_r;
    logic muted_r;
    logic [15:0] rises_r;
    wire logic unl = rate_converter_unlock_flag[0];
    wire logic wrise = output_word_clock && !wclk_r;
    wire logic bfall = !serial_bit_clock && bclk_r;

    // Bit clock idles high in reset, so the history starts high to avoid a false fall
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wclk_r <= 1'b0;
            bclk_r <= 1'b1;
            muted_r <= 1'b1;
            rises_r <= 16'h0;
        end else begin
            wclk_r <= output_word_clock;
            bclk_r <= serial_bit_clock;
            muted_r <= muted_r && unl;
            rises_r <= unl ? rises_r + {15'h0, wrise} : 16'h0;
        end
    end

    AST_UNLOCK_AT_RESET: assert property ($rose(rst_n) |-> (rate_converter_unlock_flag == 2'h3) [*8])
        else $error("unlock flag low just after reset");
    AST_FLAGS_EQUAL: assert property (rate_converter_unlock_flag[0] == rate_converter_unlock_flag[1])
        else $error("unlock flags of the two pairs differ");
    AST_MUTED_LINES: assert property (muted_r |-> !serial_out_line_a && !serial_out_line_b)
        else $error("data on a line before first lock");
    AST_LOCK_COUNT: assert property ($fell(unl) |-> $past(wrise) && rises_r >= LOCK_PERIODS)
        else $error("lock declared without enough word clock periods");
    AST_TDM_LINE_A_IDLE: assert property (format_jumper |-> !serial_out_line_a)
        else $error("line a carries data in four channel mode");
    AST_DATA_ON_BCLK_FALL: assert property (
        ($changed(serial_out_line_a) || $changed(serial_out_line_b)) && !unl && !$past(unl)
        |-> $past(bfall) or ##[1:2] unl)
        else $error("data line moved without a bit clock fall");
    AST_IWC_HALF: assert property ($rose(input_word_clock) |-> ##64 $fell(input_word_clock))
        else $error("sampling word clock high phase wrong");
    AST_IWC_PERIOD: assert property ($fell(input_word_clock) |-> ##128 $fell(input_word_clock))
        else $error("sampling word clock period wrong");

    COV_LOCK: cover property ($fell(unl));
    COV_TDM_DATA: cover property (format_jumper && serial_out_line_b);
    COV_LOCK_LOST: cover property (!unl ##1 unl);
endmodule // src_serial_audio_output_port_chk

`default_nettype wire

// File: dv/src_serial_audio_output_port_tb.sv
// Testbench: converter output end and host receiver joined over one link
`timescale 1ns/1ps
`default_nettype none

module src_serial_audio_output_port_tb;
    import audio_out_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned LOCKN = 4;
    localparam logic [3:0] STRAPS [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hb, 4'h2, 4'h6};
    localparam logic [23:0] CORNER [4] = '{24'h800000, 24'h7fffff, 24'h000000, 24'h000001};

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic button_rst_n = 1'b1;
    logic ext_rst_n = 1'b1;
    logic format_jumper = 1'b0;
    logic [STRAP_W-1:0] output_format_strap = 4'h2;
    logic [CHANNELS-1:0][ADC_BITS-1:0] sample_in = '0;
    logic [1:0] overflow_in = 2'h0;
    logic [1:0] overflow_out;
    logic [1:0] unlock;
    logic [1:0] unlock2;
    logic iwc;
    logic [SLOT_BITS-1:0] rx_word_a;
    logic [SLOT_BITS-1:0] rx_word_b;
    logic [1:0] rx_slot;
    logic rx_valid;
    int per = 256;
    int fcnt = 0;
    int n_mismatch = 0;
    int n_compared = 0;

    always #12.5 clock = ~clock;

    audio_link_if lnk ();
    audio_link_if bad ();

    // Fault driver for the second device: word clock period is set by per
    always @(posedge clock) begin
        fcnt <= (fcnt >= per - 1) ? 0 : fcnt + 1;
        bad.output_word_clock <= (fcnt < per / 2);
        bad.serial_bit_clock <= fcnt[1];
    end

    src_audio_out #(.HOLD_CYCLES(HOLD), .LOCK_PERIODS(LOCKN)) src_audio_out_i (
        .clock(clock), .rst_n(rst_n), .button_rst_n(button_rst_n), .ext_rst_n(ext_rst_n),
        .format_jumper(format_jumper), .output_format_strap(output_format_strap),
        .input_word_clock(iwc), .sample_in(sample_in), .overflow_in(overflow_in),
        .overflow_out(overflow_out), .rate_converter_unlock_flag(unlock), .link(lnk.device));
    src_audio_out #(.HOLD_CYCLES(HOLD), .LOCK_PERIODS(LOCKN)) src_audio_out_fault_i (
        .clock(clock), .rst_n(rst_n), .button_rst_n(button_rst_n), .ext_rst_n(ext_rst_n),
        .format_jumper(format_jumper), .output_format_strap(output_format_strap),
        .input_word_clock(), .sample_in(sample_in), .overflow_in(overflow_in),
        .overflow_out(), .rate_converter_unlock_flag(unlock2), .link(bad.device));
    audio_host_rx audio_host_rx_i (
        .clock(clock), .rst_n(rst_n), .tdm_mode(format_jumper), .rx_word_a(rx_word_a),
        .rx_word_b(rx_word_b), .rx_slot(rx_slot), .rx_valid(rx_valid), .link(lnk.host));
    src_serial_audio_output_port_chk #(.LOCK_PERIODS(LOCKN)) chk_i (
        .clock(clock), .rst_n(rst_n), .format_jumper(format_jumper),
        .input_word_clock(iwc), .rate_converter_unlock_flag(unlock),
        .output_word_clock(lnk.output_word_clock), .serial_bit_clock(lnk.serial_bit_clock),
        .serial_out_line_a(lnk.serial_out_line_a), .serial_out_line_b(lnk.serial_out_line_b));

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(string what, logic [1:0] exp, logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for an unlock flag value on the main or the fault device
    task automatic wait_flag(bit sel, logic [1:0] val, int lim);
        int i;
        for (i = 0; i < lim && (sel ? unlock2 : unlock) !== val; i++) begin
            @(posedge clock);
        end
        if ((sel ? unlock2 : unlock) !== val) begin
            chk_flag("unlock wait", val, sel ? unlock2 : unlock);
            finish_test();
        end
    endtask

    // Word as the host sees it: sample at the top, cut to the word length
    function automatic logic [31:0] exp_word(logic [23:0] s, int bits, bit i2s);
        logic [31:0] w;
        w = {s, 8'h00} & ~(32'hffffffff >> bits);
        return i2s ? w >> 1 : w;
    endfunction

    // Low slot bits must be zero; at 24 bits and up the whole word is exact,
    // below that dither may lift the kept word by one step at most
    task automatic check_words(int bits, bit i2s, int nw);
        int i;
        logic [31:0] lo;
        logic [31:0] cm;
        logic [31:0] st;
        logic [31:0] ea;
        logic [31:0] eb;
        logic [1:0] sl;
        lo = 32'hffffffff >> bits;
        cm = (bits >= 24) ? 32'hffffffff : lo;
        st = 32'h1 << (32 - bits);
        for (i = 0; i < 4000 && nw > 0; i++) begin
            @(posedge clock);
            if (rx_valid === 1'b1) begin
                nw--;
                // Host slots follow word clock high first, so I2S left lands in slot 1
                sl = rx_slot ^ {1'b0, i2s};
                eb = exp_word(sample_in[format_jumper ? rx_slot : 2'h2 + sl], bits, i2s);
                ea = format_jumper ? 32'h0 : exp_word(sample_in[sl], bits, i2s);
                chk_word("line b word", eb & cm, rx_word_b & cm);
                chk_word("line a word", ea & cm, rx_word_a & cm);
                if (bits < 24) begin
                    eb = (rx_word_b & ~lo) - eb;
                    ea = (rx_word_a & ~lo) - ea;
                    chk_word("line b dither step", (eb == st) ? st : 32'h0, eb);
                    chk_word("line a dither step", (ea == st) ? st : 32'h0, ea);
                end
            end
        end
        if (nw > 0) begin
            chk_word("words left", 32'h0, 32'(nw));
            finish_test();
        end
    endtask

    task automatic run_set(int k, int bits, bit i2s);
        int i;
        logic [1:0] ov;
        for (i = 0; i < CHANNELS; i++) begin
            sample_in[i] <= (k == 0) ? CORNER[i] : ADC_BITS'($urandom);
        end
        ov = 2'($urandom);
        overflow_in <= ov;
        repeat (2) @(posedge clock);
        chk_flag("overflow", ov, overflow_out);
        // Five sample periods of delay plus one frame before the new set shows
        repeat (1408) @(posedge clock);
        check_words(bits, i2s, 8);
    endtask

    initial begin
        int cfg;
        int k;
        int wl;
        int bits;
        bit i2s;
        void'($urandom(62923));
        for (cfg = 0; cfg < 7; cfg++) begin
            rst_n <= 1'b0;
            output_format_strap <= STRAPS[cfg];
            format_jumper <= (cfg == 5);
            i2s = (STRAPS[cfg][3:2] == 2'h1);
            wl = int'(STRAPS[cfg][1:0]);
            bits = (wl == 3) ? 32 : 16 + 4 * wl;
            repeat (6) @(posedge clock);
            rst_n <= 1'b1;
            repeat (2) @(posedge clock);
            chk_flag("unlock after reset", 2'h3, unlock);
            wait_flag(1'b0, 2'h0, 8000);
            for (k = 0; k < 3; k++) begin
                run_set(k, bits, i2s);
            end
            if (cfg == 2) begin
                button_rst_n <= 1'b0;
                @(posedge clock);
                button_rst_n <= 1'b1;
                repeat (HOLD) @(posedge clock);
                chk_flag("unlock in stretch", 2'h3, unlock);
                wait_flag(1'b0, 2'h0, 8000);
                ext_rst_n <= 1'b0;
                repeat (3) @(posedge clock);
                chk_flag("unlock on ext reset", 2'h3, unlock);
                ext_rst_n <= 1'b1;
                wait_flag(1'b0, 2'h0, 8000);
                run_set(1, bits, i2s);
            end
        end
        wait_flag(1'b1, 2'h0, 8000);
        per <= 300;
        wait_flag(1'b1, 2'h3, 700);
        chk_flag("unlock on rate change", 2'h3, unlock2);
        per <= 256;
        wait_flag(1'b1, 2'h0, 8000);
        chk_flag("relock", 2'h0, unlock2);
        per <= 128;
        repeat (3000) @(posedge clock);
        chk_flag("unlock rate too high", 2'h3, unlock2);
        per <= 3800;
        repeat (9000) @(posedge clock);
        chk_flag("unlock ratio too large", 2'h3, unlock2);
        finish_test();
    end
endmodule // src_serial_audio_output_port_tb

`default_nettype wire
